// >>> ssw_params.svh
/*
 * Timing constants for the supply supervisor and watchdog reset block.
 * Assumes a 125 MHz system clock.
 */
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH
`define SSW_CLK_HZ 125000000
`define SSW_RELEASE_MS 200
`define SSW_WDOG_MS 1600
`define SSW_RELEASE_CYC ((`SSW_CLK_HZ / 1000) * `SSW_RELEASE_MS)
`define SSW_WDOG_CYC ((`SSW_CLK_HZ / 1000) * `SSW_WDOG_MS)
`endif

// >>> ssw_pkg.sv
/*
 * Types for the supply supervisor block.
 * Assumes nothing beyond the params header.
 */
package ssw_pkg;
    typedef enum logic [1:0] {
        SSW_ST_HOLD = 2'b00,
        SSW_ST_RELEASE = 2'b01,
        SSW_ST_RUN = 2'b10
    } ssw_state_t;
endpackage

// >>> ssw_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes an asynchronous input and the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ssw_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Data
    input wire logic async_i,
    output logic sync_o
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic out_reg;
    logic out_next;

    always_comb
    begin
        stage_next = {stage_reg[1:0], async_i};
        out_next = out_reg;
        if (stage_reg[1] == stage_reg[2])
        begin
            out_next = stage_reg[2];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            stage_reg <= {3{RST_VAL}};
            out_reg <= RST_VAL;
        end
        else
        begin
            stage_reg <= stage_next;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;
endmodule
`default_nettype wire

// >>> ssw_supervisor.sv
/*
 * Supply supervisor: reset hold, release timeout, manual reset,
 * watchdog, write inhibit and auxiliary low flag.
 * Assumes comparator results and pins arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssw_params.svh"

// What this block does
// - Reset outputs assert while main supply is below threshold.
// - After supply recovers, reset holds for about 200 ms.
// - An outside force on reset pin starts and holds reset.
// - Any watchdog toggle edge restarts the watchdog timer.
// - Host toggles within 1.6 s, otherwise reset asserts.
// - Memory writes are inhibited while supply is below threshold.
// - Aux low output drives low while aux sense is below reference.
// - Build parameter picks dual-polarity reset or watchdog variant.
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter bit HAS_WATCHDOG = 1'b1,
    parameter int unsigned RELEASE_CYC = `SSW_RELEASE_CYC,
    parameter int unsigned WDOG_CYC = `SSW_WDOG_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Comparators, high when supply ok
    input wire logic supply_ok_i,
    input wire logic aux_sense_input_i,
    // Watchdog
    input wire logic watchdog_toggle_input_i,
    // Active-low reset pin
    input wire logic rst_n_pin_i,
    output logic rst_n_pin_o,
    output logic rst_n_pin_oe_o,
    // Active-high reset pin
    input wire logic rst_hi_pin_i,
    output logic rst_hi_pin_o,
    output logic rst_hi_pin_oe_o,
    // Aux low open drain
    output logic aux_low_output_o,
    output logic aux_low_output_oe_o,
    // Memory
    output logic write_inhibit_o,
    // Status
    output var ssw_pkg::ssw_state_t state_o
);
    import ssw_pkg::*;

    logic supply_ok_s;
    logic aux_ok_s;
    logic wdi_s;
    logic pin_n_s;
    ssw_state_t state_reg;
    ssw_state_t state_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic wdi_reg;
    logic wdi_next;
    logic drive_reg;
    logic drive_next;
    logic winh_reg;
    logic winh_next;
    logic aux_low_reg;
    logic aux_low_next;
    logic forced;
    logic wdi_edge;
    logic [3:0] quiet_reg;
    logic [3:0] quiet_next;
    logic manual_reg;
    logic manual_next;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    ssw_sync #(.RST_VAL(1'b0)) u_sync_sup (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(supply_ok_i),
        .sync_o(supply_ok_s)
    );
    ssw_sync #(.RST_VAL(1'b0)) u_sync_aux (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(aux_sense_input_i),
        .sync_o(aux_ok_s)
    );
    ssw_sync #(.RST_VAL(1'b0)) u_sync_wdi (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(watchdog_toggle_input_i),
        .sync_o(wdi_s)
    );
    ssw_sync #(.RST_VAL(1'b1)) u_sync_pin (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i(rst_n_pin_i),
        .sync_o(pin_n_s)
    );

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    // Outside force only once synchroniser has seen our release
    assign forced = !pin_n_s && !drive_reg && (quiet_reg == 4'h0);
    assign wdi_edge = HAS_WATCHDOG && (wdi_s != wdi_reg);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wdi_next = wdi_s;
        drive_next = drive_reg;
        winh_next = !supply_ok_s;
        aux_low_next = !aux_ok_s;
        quiet_next = {quiet_reg[2:0], drive_reg};
        manual_next = manual_reg && supply_ok_s;
        case (state_reg)
            SSW_ST_HOLD:
            begin
                drive_next = !(supply_ok_s && manual_reg);
                cnt_next = 32'h0;
                if (supply_ok_s && (!manual_reg || pin_n_s))
                begin
                    state_next = SSW_ST_RELEASE;
                    drive_next = 1'b1;
                    manual_next = 1'b0;
                end
            end
            SSW_ST_RELEASE:
            begin
                drive_next = 1'b1;
                if (!supply_ok_s)
                begin
                    state_next = SSW_ST_HOLD;
                    cnt_next = 32'h0;
                end
                else if (cnt_reg >= RELEASE_CYC - 1)
                begin
                    state_next = SSW_ST_RUN;
                    cnt_next = 32'h0;
                    drive_next = 1'b0;
                end
                else
                begin
                    cnt_next = cnt_reg + 32'h1;
                end
            end
            SSW_ST_RUN:
            begin
                drive_next = 1'b0;
                if (!supply_ok_s)
                begin
                    state_next = SSW_ST_HOLD;
                    drive_next = 1'b1;
                    cnt_next = 32'h0;
                end
                else if (forced)
                begin
                    state_next = SSW_ST_HOLD;
                    manual_next = 1'b1;
                    cnt_next = 32'h0;
                end
                else if (wdi_edge)
                begin
                    cnt_next = 32'h0;
                end
                else if (HAS_WATCHDOG && cnt_reg >= WDOG_CYC - 1)
                begin
                    state_next = SSW_ST_RELEASE;
                    drive_next = 1'b1;
                    cnt_next = 32'h0;
                end
                else if (HAS_WATCHDOG)
                begin
                    cnt_next = cnt_reg + 32'h1;
                end
            end
            default:
            begin
                state_next = SSW_ST_HOLD;
                drive_next = 1'b1;
                cnt_next = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= SSW_ST_HOLD;
            cnt_reg <= 32'h0;
            wdi_reg <= 1'b0;
            drive_reg <= 1'b1;
            winh_reg <= 1'b1;
            aux_low_reg <= 1'b1;
            quiet_reg <= 4'hf;
            manual_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wdi_reg <= wdi_next;
            drive_reg <= drive_next;
            winh_reg <= winh_next;
            aux_low_reg <= aux_low_next;
            quiet_reg <= quiet_next;
            manual_reg <= manual_next;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Open drain: drive low to assert, float otherwise
    assign rst_n_pin_o = 1'b0;
    assign rst_n_pin_oe_o = drive_reg;
    // Active-high: drive high to assert, float otherwise, only in the dual-polarity variant
    assign rst_hi_pin_o = 1'b1;
    assign rst_hi_pin_oe_o = !HAS_WATCHDOG && drive_reg;
    assign aux_low_output_o = 1'b0;
    assign aux_low_output_oe_o = aux_low_reg;
    assign write_inhibit_o = winh_reg;
    assign state_o = state_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_sup_low_asserts;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !supply_ok_s |=> rst_n_pin_oe_o;
    endproperty
    a_sup_low_asserts: assert property (p_sup_low_asserts) else $error("Reset not driven in low supply");

    property p_release_hold;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RELEASE) && (cnt_reg < RELEASE_CYC - 1) |=> rst_n_pin_oe_o;
    endproperty
    a_release_hold: assert property (p_release_hold) else $error("Reset released early");

    property p_release_end;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RELEASE) && supply_ok_s && (cnt_reg >= RELEASE_CYC - 1) |=> !rst_n_pin_oe_o;
    endproperty
    a_release_end: assert property (p_release_end) else $error("Reset not released after timeout");

    property p_forced;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RUN) && forced |=> (state_reg == SSW_ST_HOLD);
    endproperty
    a_forced: assert property (p_forced) else $error("Manual force ignored");

    property p_wdi_restart;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RUN) && supply_ok_s && !forced && wdi_edge |=> (cnt_reg == 32'h0);
    endproperty
    a_wdi_restart: assert property (p_wdi_restart) else $error("Toggle did not restart timer");

    property p_wdog_bound;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RUN) |-> (cnt_reg < WDOG_CYC);
    endproperty
    a_wdog_bound: assert property (p_wdog_bound) else $error("Watchdog overran period");

    property p_winh;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !supply_ok_s |=> write_inhibit_o;
    endproperty
    a_winh: assert property (p_winh) else $error("Write not inhibited");

    property p_aux;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        aux_ok_s |=> !aux_low_output_oe_o;
    endproperty
    a_aux: assert property (p_aux) else $error("Aux low stuck");

    property p_variant;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        rst_hi_pin_oe_o |-> (!HAS_WATCHDOG && rst_n_pin_oe_o);
    endproperty
    a_variant: assert property (p_variant) else $error("Active-high reset in wrong variant");

    c_release: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RELEASE) ##1 (state_reg == SSW_ST_RUN));
    c_wdog_fire: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RUN) ##1 (state_reg == SSW_ST_RELEASE));
    c_forced: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_reg == SSW_ST_RUN) && forced);
endmodule
`default_nettype wire

// >>> ssw_host.sv
/*
 * Host model: services the watchdog toggle and presses manual reset.
 * Assumes the bench owns the reset wire with its pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module ssw_host (
    // Clock
    input wire logic clk_sys_i,
    // Control from bench
    input wire logic kick_en_i,
    input wire logic press_i,
    // Pins
    output logic toggle_o,
    output logic force_low_o
);
    int cnt = 0;
    logic toggle_reg = 1'b0;
    // Kick every 64 cycles, well inside the period
    always @(negedge clk_sys_i)
    begin
        cnt <= (cnt == 63) ? 0 : cnt + 1;
        if (kick_en_i && cnt == 63)
            toggle_reg <= !toggle_reg;
    end
    assign toggle_o = toggle_reg;
    // Push-button pulls the wire low
    assign force_low_o = press_i;
endmodule
`default_nettype wire

// >>> test_ssw_supervisor.sv
/*
 * Self-checking bench for the supervisor with host model.
 * Assumes short counts: release 50, watchdog 200 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module test_ssw_supervisor;
    import ssw_pkg::*;
    logic clk_sys_i = 0, sys_rst_i = 1, supply_ok_i = 0, aux_i = 0;
    logic kick_en = 0, press = 0, toggle, force_low, rst_n_wire;
    logic rst_n_pin_oe_o, write_inhibit_o, aux_oe, dual_oe, dual_hi_oe;
    ssw_state_t state_o;
    int n_mismatch = 0, comparisons = 0, n, cycles = 0, hi_cnt = 0, h0;
    logic [3:0] rows [4] = '{4'b0011, 4'b0110, 4'b1001, 4'b1100};
    // Pull-up on the active-low reset wire
    assign rst_n_wire = !(rst_n_pin_oe_o || force_low);
    always #4 clk_sys_i = !clk_sys_i;
    ssw_supervisor #(.HAS_WATCHDOG(1'b1), .RELEASE_CYC(50), .WDOG_CYC(200)) ssw_supervisor_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
        .aux_sense_input_i(aux_i), .watchdog_toggle_input_i(toggle),
        .rst_n_pin_i(rst_n_wire), .rst_n_pin_o(), .rst_n_pin_oe_o(rst_n_pin_oe_o),
        .rst_hi_pin_i(1'b0), .rst_hi_pin_o(), .rst_hi_pin_oe_o(),
        .aux_low_output_o(), .aux_low_output_oe_o(aux_oe),
        .write_inhibit_o(write_inhibit_o), .state_o(state_o));
    // Dual-polarity variant without watchdog, sharing the supply stimulus
    if (1)
    begin : g_dual
        ssw_supervisor #(.HAS_WATCHDOG(1'b0), .RELEASE_CYC(50), .WDOG_CYC(200)) ssw_supervisor_i (
            .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
            .aux_sense_input_i(aux_i), .watchdog_toggle_input_i(toggle),
            .rst_n_pin_i(!dual_oe), .rst_n_pin_o(), .rst_n_pin_oe_o(dual_oe),
            .rst_hi_pin_i(1'b0), .rst_hi_pin_o(), .rst_hi_pin_oe_o(dual_hi_oe),
            .aux_low_output_o(), .aux_low_output_oe_o(),
            .write_inhibit_o(), .state_o());
    end
    ssw_host ssw_host_i (.clk_sys_i(clk_sys_i), .kick_en_i(kick_en), .press_i(press),
        .toggle_o(toggle), .force_low_o(force_low));
    // -----------------------------
    // Helpers
    // -----------------------------
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    task automatic wait_oe(input logic v, output int m);
        m = 0;
        while (rst_n_pin_oe_o !== v && m < 1000)
        begin
            cyc(1);
            m++;
        end
    endtask
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (rst_n_pin_oe_o === 1'b1)
            hi_cnt++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    // -----------------------------
    // Sequence
    // -----------------------------
    initial
    begin
        cyc(3);
        check(rst_n_pin_oe_o, 1);
        check(write_inhibit_o, 1);
        check(dual_hi_oe, 1);
        sys_rst_i = 0;
        foreach (rows[i])
        begin
            {supply_ok_i, aux_i} = rows[i][3:2];
            cyc(10);
            check(write_inhibit_o, rows[i][1]);
            check(aux_oe, rows[i][0]);
        end
        supply_ok_i = 0;
        cyc(10);
        kick_en = 1;
        supply_ok_i = 1;
        cyc(10);
        check(write_inhibit_o, 0);
        check(rst_n_pin_oe_o, 1);
        wait_oe(0, n);
        check(n >= 43 && n <= 50, 1);
        check(dual_hi_oe, 0);
        check(state_o, SSW_ST_RUN);
        h0 = hi_cnt;
        cyc(600);
        check(hi_cnt - h0, 0);
        @(toggle);
        cyc(1);
        kick_en = 0;
        wait_oe(1, n);
        check(n >= 195 && n <= 210, 1);
        check(dual_hi_oe, 0);
        wait_oe(0, n);
        check(n >= 49 && n <= 56, 1);
        kick_en = 1;
        cyc(20);
        press = 1;
        cyc(8);
        check(state_o, SSW_ST_HOLD);
        cyc(100);
        check(state_o, SSW_ST_HOLD);
        check(rst_n_wire, 0);
        press = 0;
        wait_oe(1, n);
        check(n <= 8, 1);
        wait_oe(0, n);
        check(n >= 49 && n <= 60, 1);
        supply_ok_i = 0;
        wait_oe(1, n);
        check(n <= 8, 1);
        check(dual_hi_oe, 1);
        check(write_inhibit_o, 1);
        print_verdict();
    end
endmodule
`default_nettype wire
